// >>> hw/ncd_pkg.sv
// What this block does
// - Nine independent channels, each with its own 8-bit register holding a 7-bit duty value.
// - Each output pattern repeats every 128 tick periods.
// - High time equals duty value ticks; tick runs at one quarter of clock.
// - Outputs are fixed active high; nothing inverts them.
// - Bit 7 enables the channel; when clear the pin is a port line.
// - Bits 6 to 0 hold the duty value, bit 6 most significant.
// - Channel 0 shares port 1 line 3; channels 1 to 8 share port 0.
`default_nettype none
package ncd_pkg;
  localparam int          NUM_CH        = 9;
  localparam int          DUTY_W        = 7;
  localparam int          REG_W         = 8;
  localparam int          ADDR_W        = 8;
  localparam int          ENABLE_BIT    = 7;
  localparam int          DUTY_MSB      = 6;
  localparam int          DUTY_LSB      = 0;
  localparam int          TICK_DIV      = 4;
  localparam int          PERIOD_TICKS  = 128;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  // Printed offsets are register indices; byte address is four times that
  localparam logic [7:0]  IDX_CH0       = 8'h86;
  localparam logic [7:0]  IDX_CH1       = 8'h96;
  localparam logic [7:0]  IDX_CH2       = 8'hA6;
  localparam logic [7:0]  IDX_CH3       = 8'hB6;
  localparam logic [7:0]  IDX_CH4       = 8'hC6;
  localparam logic [7:0]  IDX_CH5       = 8'hD6;
  localparam logic [7:0]  IDX_CH6       = 8'hE6;
  localparam logic [7:0]  IDX_CH7       = 8'hF6;
  localparam logic [7:0]  IDX_CH8       = 8'hF5;
  // Status word: tick count of the running period, read only
  localparam logic [7:0]  IDX_STATUS    = 8'hF7;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> hw/ncd_channel.sv
`timescale 1ns/1ps
`default_nettype none
module ncd_channel (
  input  wire logic       ref_clk,     // System clock
  input  wire logic       rstn,        // Async reset, active low
  input  wire logic [7:0] ctrl,        // Channel register
  input  wire logic [6:0] count,       // Shared tick count
  input  wire logic       tick,        // Tick strobe
  input  wire logic       wrap,        // Last tick of period
  output logic            pwm          // Active-high duty output
);
  typedef struct packed {
    logic [6:0] duty;
    logic       en;
    logic       out;
  } ncd_ch_t;

  ncd_ch_t st;
  ncd_ch_t next_st;

  // Latch the register only at the period boundary to avoid runt pulses
  always_comb begin
    next_st = st;
    if (tick && wrap) begin
      next_st.duty = ctrl[ncd_pkg::DUTY_MSB:ncd_pkg::DUTY_LSB];
      next_st.en   = ctrl[ncd_pkg::ENABLE_BIT];
    end
    // High while count below duty, never inverted
    next_st.out = next_st.en && (count < next_st.duty);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pwm = st.out;

  // Disabled channel stays low on its pulse output
  off_low_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !st.en |-> !pwm) else $error("disabled channel drives high");

  // Duty only moves at the period boundary, so a write never cuts a pulse short
  duty_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(tick && wrap) |=> $stable(st.duty))
    else $error("duty changed inside a period");
  duty_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    tick && wrap |=> st.duty == $past(ctrl[ncd_pkg::DUTY_MSB:ncd_pkg::DUTY_LSB]))
    else $error("duty not loaded at the boundary");
endmodule
`default_nettype wire

// >>> hw/ncd_top.sv
`timescale 1ns/1ps
`default_nettype none
module ncd_top #(
  parameter int NUM_CH = ncd_pkg::NUM_CH   // Channel count
) (
  input  wire logic        ref_clk,          // 125 MHz clock
  input  wire logic        rstn,             // Async reset, active low
  input  wire logic [9:0]  avs_address,      // Byte address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [31:0] avs_writedata,    // Write data
  input  wire logic [3:0]  avs_byteenable,   // Byte lanes
  output logic [31:0]      avs_readdata,     // Read data
  output logic             avs_waitrequest,  // Stall
  input  wire logic [7:0]  port_zero_lines,  // Port 0 GPIO output levels
  input  wire logic        port1_line3,      // Port 1 line 3 GPIO level
  output logic [7:0]       port_zero_out,    // Port 0 pin drive
  output logic             port1_line3_out,  // Port 1 line 3 pin drive
  output logic [8:0]       duty_channel_enable // Pin owned by channel
);
  localparam logic [6:0] LAST_COUNT = 7'(ncd_pkg::PERIOD_TICKS - 1);
  localparam logic [1:0] LAST_DIV   = 2'(ncd_pkg::TICK_DIV - 1);

  // Map byte address index to channel number, all ones when unmapped
  function automatic logic [3:0] ch_of(input logic [7:0] idx);
    unique case (idx)
      ncd_pkg::IDX_CH0: ch_of = 4'h0;
      ncd_pkg::IDX_CH1: ch_of = 4'h1;
      ncd_pkg::IDX_CH2: ch_of = 4'h2;
      ncd_pkg::IDX_CH3: ch_of = 4'h3;
      ncd_pkg::IDX_CH4: ch_of = 4'h4;
      ncd_pkg::IDX_CH5: ch_of = 4'h5;
      ncd_pkg::IDX_CH6: ch_of = 4'h6;
      ncd_pkg::IDX_CH7: ch_of = 4'h7;
      ncd_pkg::IDX_CH8: ch_of = 4'h8;
      default:          ch_of = 4'hF;
    endcase
  endfunction

  typedef struct packed {
    logic [8:0][7:0] regs;
    logic [1:0]      div;
    logic [6:0]      count;
    logic            tick;
    logic            wrap;
    logic [31:0]     rdata;
    logic            ack;
    logic            waitreq;
    logic [7:0]      p0_sync1;
    logic [7:0]      p0_sync2;
    logic            p1_sync1;
    logic            p1_sync2;
    logic [7:0]      p0_out;
    logic            p1_out;
    logic [8:0]      own;
  } ncd_top_t;

  ncd_top_t st;
  ncd_top_t next_st;
  logic [8:0] pwm;
  logic [7:0] idx;
  logic [3:0] sel;

  assign idx = avs_address[9:2];
  assign sel = ch_of(idx);

  // Tick divider, counter and bus slave with one wait state
  always_comb begin
    next_st = st;
    next_st.div  = st.div + 2'h1;
    next_st.tick = (st.div == LAST_DIV);
    next_st.wrap = (st.count == LAST_COUNT);
    if (st.tick) begin
      next_st.count = st.count + 7'h01;
    end
    next_st.p0_sync1 = port_zero_lines;
    next_st.p0_sync2 = st.p0_sync1;
    next_st.p1_sync1 = port1_line3;
    next_st.p1_sync2 = st.p1_sync1;
    // Stall idles high once clocked out of reset (reset loads it low), so each request after that sees exactly one wait state
    next_st.ack     = 1'b0;
    next_st.waitreq = 1'b1;
    if ((avs_read || avs_write) && !st.ack) begin
      next_st.ack     = 1'b1;
      next_st.waitreq = 1'b0;
      next_st.rdata = ncd_pkg::UNMAPPED_DATA;
      if (avs_write && sel != 4'hF && avs_byteenable[0]) begin
        next_st.regs[sel] = avs_writedata[7:0];
      end
      if (avs_read && sel != 4'hF) begin
        next_st.rdata = {24'h000000, st.regs[sel]};
      end else if (avs_read && idx == ncd_pkg::IDX_STATUS) begin
        next_st.rdata = {25'h0000000, st.count};
      end
    end
    // Pin mux: pulse when enabled, else the port latch
    for (int i = 0; i < 8; i++) begin
      next_st.p0_out[i] = st.regs[i+1][ncd_pkg::ENABLE_BIT] ? pwm[i+1] : st.p0_sync2[i];
    end
    next_st.p1_out = st.regs[0][ncd_pkg::ENABLE_BIT] ? pwm[0] : st.p1_sync2;
    for (int i = 0; i < 9; i++) begin
      next_st.own[i] = st.regs[i][ncd_pkg::ENABLE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // One instance per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      ncd_channel u_ch (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ctrl    (st.regs[g]),
        .count   (st.count),
        .tick    (st.tick),
        .wrap    (st.wrap),
        .pwm     (pwm[g])
      );
    end
  endgenerate

  assign avs_readdata        = st.rdata;
  assign avs_waitrequest     = st.waitreq; // Low in the answer cycle, and from reset until the first clock edge
  assign port_zero_out       = st.p0_out;
  assign port1_line3_out     = st.p1_out;
  assign duty_channel_enable = st.own;

  tick_rate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.tick |=> !st.tick [*3] ##1 st.tick) else $error("tick not every fourth clock");
  count_step_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.tick |=> st.count == $past(st.count) + 7'h01) else $error("count did not step");

  // Bus answer comes one cycle after the request is taken, and lasts one cycle
  wait_one_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (avs_read || avs_write) && !st.ack |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  ack_once_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held for more than one cycle");
  // Disabled channel zero hands its pin back to the synced port level
  mux_port_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !st.regs[0][ncd_pkg::ENABLE_BIT] |=> port1_line3_out == $past(st.p1_sync2))
    else $error("port line not passed through");
endmodule
`default_nettype wire

// >>> testbench/ncd_rc_model.sv
`timescale 1ns/1ps
`default_nettype none
// RC integrator stand-in: charge counts clocks the pin spends high
module ncd_rc_model (
  input  wire logic ref_clk, // System clock
  input  wire logic pin,     // Channel pin
  input  wire logic clr,     // Discharge
  output int        level    // Integrated charge
);
  // Counting in clocks keeps the model exact, unlike a real RC ripple
  always @(posedge ref_clk) begin
    level <= clr ? 0 : level + int'(pin);
  end
endmodule
`default_nettype wire

// >>> testbench/nine_channel_duty_dac_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module nine_channel_duty_dac_tb;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest;
  logic [7:0]  port_zero_lines = 8'h00;
  logic [7:0]  port_zero_out;
  logic        port1_line3 = 1'b0;
  logic        port1_line3_out;
  logic        clr = 1'b1;
  logic [8:0]  duty_channel_enable;
  logic [8:0]  pins;
  logic [7:0]  idx [9] = '{8'h86, 8'h96, 8'hA6, 8'hB6, 8'hC6, 8'hD6, 8'hE6, 8'hF6, 8'hF5};
  int          level [9];
  int          duty [9];
  int          seed = 35;
  int          n_errors = 0;
  int          checks_done = 0;
  // Clock and pin map, channel 0 on port 1 line 3
  always #4 ref_clk = ~ref_clk;
  assign pins = {port_zero_out, port1_line3_out};
  ncd_top ncd_top_i (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port_zero_lines(port_zero_lines),
    .port1_line3(port1_line3), .port_zero_out(port_zero_out), .port1_line3_out(port1_line3_out),
    .duty_channel_enable(duty_channel_enable));
  for (genvar c = 0; c < 9; c++) begin : g_rc
    ncd_rc_model ncd_rc_model_i (.ref_clk(ref_clk), .pin(pins[c]), .clr(clr), .level(level[c]));
  end
  // One Avalon transfer; the opening edge keeps back-to-back calls apart
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard, well past the expected run
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    // Cleared after reset, unmapped place reads zero
    for (int c = 0; c < 9; c++) begin
      bus(1'b0, idx[c], 32'h0);
      `CHK(rd, 32'h0)
    end
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    // Write without byte lane 0 must be ignored
    be <= 4'hE;
    bus(1'b1, idx[0], 32'hFF);
    be <= 4'hF;
    bus(1'b0, idx[0], 32'h0);
    `CHK(rd, 32'h0)
    // Duty 0 and 127 boundaries, random rest; junk in upper bits
    for (int c = 0; c < 9; c++) begin
      duty[c] = (c == 0) ? 0 : (c == 1) ? 127 : ($random(seed) & 127);
      bus(1'b1, idx[c], 32'hFFFF_FF80 | duty[c]);
      bus(1'b0, idx[c], 32'h0);
      `CHK(rd, 32'h80 | duty[c])
    end
    port_zero_lines <= 8'($random(seed));
    port1_line3 <= 1'($random(seed));
    // New values land only at a wrap, so settle before measuring
    repeat (1024) @(posedge ref_clk);
    clr <= 1'b0;
    repeat (512) @(posedge ref_clk);
    clr <= 1'b1;
    @(negedge ref_clk);
    for (int c = 0; c < 9; c++) `CHK(level[c], duty[c] * 4)
    `CHK(level[1], 508)
    `CHK(duty_channel_enable, 9'h1FF)
    // Status word carries only the 7-bit tick count
    bus(1'b0, 8'hF7, 32'h0);
    `CHK(rd[31:7], 25'h0)
    // Disabled channels hand pins back to the port lines
    for (int c = 0; c < 9; c++) bus(1'b1, idx[c], duty[c]);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(port_zero_out, port_zero_lines)
    `CHK(port1_line3_out, port1_line3)
    `CHK(duty_channel_enable, 9'h000)
    // Mid-run reset clears pins, read data and the channel 1 register
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(negedge ref_clk);
    `CHK({port_zero_out, port1_line3_out}, 9'h000)
    `CHK(avs_readdata, 32'h0)
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, idx[1], 32'h0);
    `CHK(rd, 32'h0)
    stop_test();
  end
endmodule
`default_nettype wire
